/* dv/vram_ctrl_strobe_refresh_extras_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module vram_ctrl_strobe_refresh_extras_tb_top;
    logic clk;
    logic reset;
    vrc_pkg::vrc_pins_type pins;
    vrc_pkg::vrc_drive_type drive;
    vrc_pkg::vrc_mode_type mode_status;
    int n_fail;
    int cmp_count;

    vrc_strobe_refresh DUT
    (
        .clk(clk),
        .reset(reset),
        .pins(pins),
        .drive(drive),
        .mode_status(mode_status)
    );

    vrc_host_model host
    (
        .clk(clk),
        .pins(pins)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    function automatic logic sel_bit(input int s);
        case (s)
            0: return drive.ras;
            1: return drive.cas;
            2: return drive.transfer_output_enable;
            3: return drive.transfer_acknowledge;
            default: return drive.refresh_request_out;
        endcase
    endfunction

    // n counts edges from the call to the wanted level
    task automatic wait_bit(input int s, input logic v, input int lim, output int n);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (sel_bit(s) !== v && n < lim);
        `CHK("wait_bit", v, sel_bit(s))
    endtask

    task automatic prog(input logic [3:0] m);
        host.program_mode(m);
        tick(4);
        `CHK("mode", m, mode_status)
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        `CHK("drv_rst", 6'h00, drive)
        `CHK("mode_rst", 4'h0, mode_status)
        $display("test reset done");
    endtask

    task automatic t_read_ext();
        int n;
        prog(4'h0);
        host.access(1'b1, 1'b0, 2'h0);
        wait_bit(3, 1'b1, 8, n);
        `CHK("ack_lat", 5, n)
        `CHK("oe_rd", 1'b1, drive.transfer_output_enable)
        host.access(1'b0, 1'b0, 2'h2);
        tick(3);
        `CHK("ras_end", 1'b0, drive.ras)
        `CHK("ack_end", 1'b0, drive.transfer_acknowledge)
        `CHK("cas_ext", 1'b1, drive.cas)
        `CHK("oe_ext", 1'b1, drive.transfer_output_enable)
        tick(4);
        `CHK("cas_hold", 1'b1, drive.cas)
        host.access(1'b0, 1'b0, 2'h0);
        wait_bit(1, 1'b0, 6, n);
        `CHK("cas_fall", 3, n)
        `CHK("oe_fall", 1'b0, drive.transfer_output_enable)
        tick(8);
        $display("test read_ext done");
    endtask

    task automatic t_write();
        int n;
        host.access(1'b1, 1'b1, 2'h0);
        wait_bit(3, 1'b1, 8, n);
        `CHK("cas_wr", 1'b1, drive.cas)
        `CHK("oe_wr", 1'b0, drive.transfer_output_enable)
        host.access(1'b0, 1'b1, 2'h0);
        wait_bit(3, 1'b0, 6, n);
        `CHK("ack_drop", 3, n)
        tick(8);
        $display("test write done");
    endtask

    task automatic t_shift();
        int n;
        prog(4'h0);
        host.shift(1'b1);
        wait_bit(2, 1'b1, 6, n);
        tick(6);
        `CHK("oe_follow", 1'b1, drive.transfer_output_enable)
        host.shift(1'b0);
        wait_bit(2, 1'b0, 6, n);
        `CHK("oe_rel", 3, n)
        prog(4'h8);
        host.shift(1'b1);
        wait_bit(2, 1'b1, 6, n);
        tick(2);
        `CHK("oe_e3", 1'b1, drive.transfer_output_enable)
        tick(1);
        `CHK("oe_e4", 1'b0, drive.transfer_output_enable)
        host.shift(1'b0);
        tick(6);
        host.shift(1'b1);
        host.shift(1'b0);
        wait_bit(2, 1'b1, 6, n);
        tick(1);
        `CHK("oe_short", 1'b0, drive.transfer_output_enable)
        tick(6);
        $display("test shift done");
    endtask

    task automatic t_grant();
        int d [3];
        prog(4'h0);
        host.access(1'b1, 1'b0, 2'h0);
        wait_bit(0, 1'b1, 8, d[0]);
        `CHK("ras_lat", 3, d[0])
        host.access(1'b0, 1'b0, 2'h0);
        tick(10);
        for (int i = 1; i < 3; i++)
        begin
            prog(i == 2 ? 4'h4 : 4'h0);
            host.grant_access();
            wait_bit(0, 1'b1, 8, d[i]);
            `CHK("grant_ras", d[0] + i, d[i])
            host.access(1'b0, 1'b0, 2'h0);
            tick(10);
        end
        $display("test grant done");
    endtask

    // precharge gaps are compared against code 00, refresh widths absolutely
    task automatic t_timing();
        logic [2:0] pre [4];
        logic [2:0] rw [4];
        int g [4];
        int n;
        pre = '{vrc_pkg::VRC_PRE_00, vrc_pkg::VRC_PRE_01, vrc_pkg::VRC_PRE_10, vrc_pkg::VRC_PRE_11};
        rw = '{vrc_pkg::VRC_REF_00, vrc_pkg::VRC_REF_01, vrc_pkg::VRC_REF_10, vrc_pkg::VRC_REF_11};
        for (int c = 0; c < 4; c++)
        begin
            prog({1'b1, 2'(c), 1'b0});
            host.access(1'b1, 1'b0, 2'h0);
            wait_bit(3, 1'b1, 8, n);
            host.access(1'b0, 1'b0, 2'h0);
            host.access(1'b1, 1'b0, 2'h0);
            wait_bit(0, 1'b0, 6, n);
            wait_bit(0, 1'b1, 12, g[c]);
            `CHK("pre_gap", int'(pre[c]) - int'(pre[0]), g[c] - g[0])
            host.access(1'b0, 1'b0, 2'h0);
            tick(8);
            wait_bit(4, 1'b1, 400, n);
            host.refresh(1'b1, 1'b1);
            host.refresh(1'b1, 1'b0);
            wait_bit(0, 1'b1, 8, n);
            n = 0;
            while (drive.ras === 1'b1 && n < 8)
            begin
                `CHK("refresh_in_progress_out", 1'b1, drive.refresh_status_pin)
                tick(1);
                n++;
            end
            `CHK("ref_w", int'(rw[c]), n)
            `CHK("req_clr", 1'b0, drive.refresh_request_out)
            tick(8);
        end
        $display("test timing done");
    endtask

    task automatic t_clear();
        int n;
        prog(4'h0);
        host.refresh(1'b0, 1'b0);
        wait_bit(4, 1'b1, 400, n);
        `CHK("refresh_request_out_pin", 1'b1, drive.refresh_status_pin)
        tick(100);
        host.clear_counter();
        wait_bit(4, 1'b1, 400, n);
        `CHK("clr_late", 1'b1, n > 330)
        $display("test clear done");
    endtask

    // the increment input stretches refresh ras; interleaved mode never stretches cas
    task automatic t_extras();
        int n;
        prog(4'h8);
        host.refresh_extend(1'b1);
        wait_bit(0, 1'b1, 400, n);
        tick(8);
        `CHK("ref_ext", 1'b1, drive.ras)
        `CHK("refresh_in_progress_out_ext", 1'b1, drive.refresh_status_pin)
        host.refresh_extend(1'b0);
        wait_bit(0, 1'b0, 6, n);
        `CHK("ref_ext_end", 3, n)
        tick(8);
        prog(4'h1);
        host.access(1'b1, 1'b0, 2'h0);
        wait_bit(3, 1'b1, 8, n);
        host.access(1'b0, 1'b0, 2'h1);
        wait_bit(1, 1'b0, 6, n);
        `CHK("cas_il", 3, n)
        `CHK("ras_il", 1'b0, drive.ras)
        host.access(1'b0, 1'b0, 2'h0);
        prog(4'h0);
        host.access(1'b1, 1'b1, 2'h0);
        wait_bit(3, 1'b1, 8, n);
        host.access(1'b0, 1'b1, 2'h1);
        wait_bit(0, 1'b0, 6, n);
        `CHK("cas_ext1", 1'b1, drive.cas)
        `CHK("oe_ext_wr", 1'b0, drive.transfer_output_enable)
        host.access(1'b0, 1'b1, 2'h0);
        tick(8);
        $display("test extras done");
    endtask

    // ****************************************
    // clock, watchdog, main sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // the tests need about 2800 clocks; the margin is generous
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    initial
    begin
        reset = 1'b1;
        n_fail = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        #1;
        reset = 1'b0;
        tick(2);
        t_reset();
        t_read_ext();
        t_write();
        t_shift();
        t_grant();
        t_timing();
        t_clear();
        t_extras();
        give_verdict();
    end
endmodule

`undef CHK
`default_nettype wire

/* dv/vrc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module vrc_host_model
(
    input wire logic clk,
    output var vrc_pkg::vrc_pins_type pins
);
    // ****************************************
    // host side pin driver
    // ****************************************
    initial
    begin
        pins = '0;
        pins.internal_refresh_disable = 1'b1;
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // m is {option, timing low, timing high, interleave}
    task automatic program_mode(input logic [3:0] m);
        step();
        {pins.column_extend_option_input, pins.ras_timing_bit_low, pins.ras_timing_bit_high, pins.interleave_mode} = m;
        pins.program_strobe = 1'b1;
        step();
        pins.program_strobe = 1'b0;
    endtask

    // extend inputs may stay up after the request drops, stretching cas
    task automatic access(input logic req, input logic wr, input logic [1:0] ext);
        step();
        pins.access_request = req;
        pins.access_is_write = wr;
        pins.column_extend_inputs = ext;
    endtask

    task automatic shift(input logic v);
        step();
        pins.shift_load_request = v;
    endtask

    task automatic grant_access();
        step();
        pins.second_port_grant = ~pins.second_port_grant;
        pins.access_request = 1'b1;
    endtask

    // a held increment input keeps a refresh going; the system ties it low when unused
    task automatic refresh_extend(input logic v);
        step();
        pins.column_increment_in = v;
    endtask

    task automatic refresh(input logic dis, input logic stb);
        step();
        pins.internal_refresh_disable = dis;
        pins.refresh_strobe_in = stb;
    endtask

    // 13 clocks is 520 ns, just over the minimum hold
    task automatic clear_counter();
        step();
        pins.internal_refresh_disable = 1'b0;
        pins.refresh_strobe_in = 1'b1;
        repeat (13) step();
        pins.refresh_strobe_in = 1'b0;
    endtask
endmodule

`default_nettype wire

/* hdl/vrc_strobe_refresh.sv */
// How it works
// - non-interleaved, option negated: cas held after request drops while any extend input asserted, unless the grant changes in the same cycle
// - ras falls when the access request drops, even with cas extended
// - transfer acknowledge ends when the request drops, regardless of cas extension
// - output enable follows cas on reads and stays negated on writes
// - option negated: output enable follows the shift-load request
// - option asserted: shift-load asserts output enable; early release negates it
// - option asserted: output enable negated at the fourth edge of a long shift-load
// - ras asserts one edge after grant change, two when low timing bit set
// - timing bit pair sets precharge and refresh ras-low clocks
// - refresh counter always runs and raises the request even with refresh disabled
// - latched option picks refresh status pin role: in-progress or request
// - strobe held 500 ns with disable negated clears the refresh counter
`timescale 1ns/10ps
`default_nettype none

module vrc_strobe_refresh
(
    input wire logic clk,
    input wire logic reset,
    input wire vrc_pkg::vrc_pins_type pins,
    output vrc_pkg::vrc_drive_type drive,
    output vrc_pkg::vrc_mode_type mode_status
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        vrc_pkg::vrc_pins_type sync_a;
        vrc_pkg::vrc_pins_type sync_b;
        vrc_pkg::vrc_mode_type mode;
        vrc_pkg::vrc_state_type state;
        logic [2:0] cnt;
        logic grant_prev;
        logic [1:0] grant_wait;
        logic [8:0] refresh_cnt;
        logic refresh_due;
        logic [3:0] strobe_cnt;
        logic [2:0] shift_edges;
        vrc_pkg::vrc_drive_type drive;
    } vrc_regs_type;

    vrc_regs_type s;
    vrc_regs_type next_s;
    vrc_pkg::vrc_pins_type p;
    logic tick;
    logic clear;
    logic grant_changed;
    logic refresh_go;

    assign p = s.sync_b;
    assign drive = s.drive;
    assign mode_status = s.mode;

    // ****************************************
    // timing decode
    // ****************************************
    function automatic logic [2:0] vrc_precharge(input vrc_pkg::vrc_mode_type m);
        case ({m.ras_timing_bit_low, m.ras_timing_bit_high})
            2'h0: vrc_precharge = vrc_pkg::VRC_PRE_00;
            2'h1: vrc_precharge = vrc_pkg::VRC_PRE_01;
            2'h2: vrc_precharge = vrc_pkg::VRC_PRE_10;
            default: vrc_precharge = vrc_pkg::VRC_PRE_11;
        endcase
    endfunction

    function automatic logic [2:0] vrc_refresh_low(input vrc_pkg::vrc_mode_type m);
        case ({m.ras_timing_bit_low, m.ras_timing_bit_high})
            2'h0: vrc_refresh_low = vrc_pkg::VRC_REF_00;
            2'h1: vrc_refresh_low = vrc_pkg::VRC_REF_01;
            2'h2: vrc_refresh_low = vrc_pkg::VRC_REF_10;
            default: vrc_refresh_low = vrc_pkg::VRC_REF_11;
        endcase
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_s = s;
        next_s.sync_a = pins;
        next_s.sync_b = s.sync_a;

        // option stays in force until the next programming strobe
        if (p.program_strobe)
        begin
            next_s.mode.column_extend_option = p.column_extend_option_input;
            next_s.mode.ras_timing_bit_low = p.ras_timing_bit_low;
            next_s.mode.ras_timing_bit_high = p.ras_timing_bit_high;
            next_s.mode.interleave_mode = p.interleave_mode;
        end

        // refresh clock runs whatever the disable input says
        tick = (s.refresh_cnt == vrc_pkg::VRC_REFRESH_LAST);
        clear = p.refresh_strobe_in && !p.internal_refresh_disable
            && (s.strobe_cnt == vrc_pkg::VRC_CLEAR_LAST);
        if (p.refresh_strobe_in && !p.internal_refresh_disable)
        begin
            if (s.strobe_cnt != vrc_pkg::VRC_CLEAR_DONE)
            begin
                next_s.strobe_cnt = s.strobe_cnt + 4'h1;
            end
        end
        else
        begin
            next_s.strobe_cnt = 4'h0;
        end
        if (clear || tick)
        begin
            next_s.refresh_cnt = 9'h000;
        end
        else
        begin
            next_s.refresh_cnt = s.refresh_cnt + 9'h001;
        end
        next_s.refresh_due = s.refresh_due || tick;

        // port change: ras held off for one or two edges
        grant_changed = (p.second_port_grant != s.grant_prev);
        next_s.grant_prev = p.second_port_grant;
        if (grant_changed)
        begin
            next_s.grant_wait = s.mode.ras_timing_bit_low ? vrc_pkg::VRC_GRANT_DELAY_LONG
                : vrc_pkg::VRC_GRANT_DELAY_SHORT;
        end
        else if (s.grant_wait != 2'h0)
        begin
            next_s.grant_wait = s.grant_wait - 2'h1;
        end

        // external acknowledge style refresh also serves a due refresh
        refresh_go = s.refresh_due && (!p.internal_refresh_disable || p.refresh_strobe_in);

        case (s.state)
            vrc_pkg::VRC_IDLE:
            begin
                if (p.shift_load_request)
                begin
                    // shift-load owns the output enable while idle
                    if (!s.mode.column_extend_option)
                    begin
                        next_s.drive.transfer_output_enable = 1'b1;
                    end
                    else
                    begin
                        if (s.shift_edges != vrc_pkg::VRC_SHIFT_EDGES)
                        begin
                            next_s.shift_edges = s.shift_edges + 3'h1;
                        end
                        next_s.drive.transfer_output_enable =
                            (next_s.shift_edges < vrc_pkg::VRC_SHIFT_EDGES);
                    end
                end
                else
                begin
                    next_s.shift_edges = 3'h0;
                    next_s.drive.transfer_output_enable = 1'b0;
                    if (refresh_go)
                    begin
                        next_s.refresh_due = tick;
                        next_s.state = vrc_pkg::VRC_REF;
                        next_s.drive.ras = 1'b1;
                        next_s.cnt = vrc_refresh_low(s.mode) - 3'h1;
                    end
                    else if (p.access_request && !grant_changed && s.grant_wait < 2'h2)
                    begin
                        next_s.state = vrc_pkg::VRC_ROW;
                        next_s.drive.ras = 1'b1;
                    end
                end
            end
            vrc_pkg::VRC_ROW:
            begin
                if (grant_changed || !p.access_request)
                begin
                    next_s.drive.ras = 1'b0;
                    next_s.cnt = vrc_precharge(s.mode) - 3'h1;
                    next_s.state = vrc_pkg::VRC_PRE;
                end
                else
                begin
                    next_s.drive.cas = 1'b1;
                    next_s.drive.transfer_output_enable = !p.access_is_write;
                    next_s.state = vrc_pkg::VRC_COL;
                end
            end
            vrc_pkg::VRC_COL:
            begin
                next_s.drive.transfer_output_enable = !p.access_is_write;
                next_s.drive.transfer_acknowledge = 1'b1;
                if (!p.access_request || grant_changed)
                begin
                    next_s.drive.ras = 1'b0;
                    next_s.drive.transfer_acknowledge = 1'b0;
                    next_s.cnt = vrc_precharge(s.mode) - 3'h1;
                    // precharge runs under the extended cas, which is its point
                    if (!s.mode.interleave_mode && !s.mode.column_extend_option
                        && (p.column_extend_inputs != 2'h0) && !grant_changed)
                    begin
                        next_s.state = vrc_pkg::VRC_EXT;
                    end
                    else
                    begin
                        next_s.drive.cas = 1'b0;
                        next_s.drive.transfer_output_enable = 1'b0;
                        next_s.state = vrc_pkg::VRC_PRE;
                    end
                end
            end
            vrc_pkg::VRC_EXT:
            begin
                if (s.cnt != 3'h0)
                begin
                    next_s.cnt = s.cnt - 3'h1;
                end
                if (p.column_extend_inputs == 2'h0)
                begin
                    next_s.drive.cas = 1'b0;
                    next_s.drive.transfer_output_enable = 1'b0;
                    next_s.state = vrc_pkg::VRC_PRE;
                end
            end
            vrc_pkg::VRC_REF:
            begin
                if (s.cnt != 3'h0)
                begin
                    next_s.cnt = s.cnt - 3'h1;
                end
                else if (!p.column_increment_in)
                begin
                    // a stuck-high increment input would hold ras low forever
                    next_s.drive.ras = 1'b0;
                    next_s.cnt = vrc_precharge(s.mode) - 3'h1;
                    next_s.state = vrc_pkg::VRC_PRE;
                end
            end
            vrc_pkg::VRC_PRE:
            begin
                if (s.cnt != 3'h0)
                begin
                    next_s.cnt = s.cnt - 3'h1;
                end
                else
                begin
                    next_s.state = vrc_pkg::VRC_IDLE;
                end
            end
            default:
            begin
                next_s.state = vrc_pkg::VRC_IDLE;
            end
        endcase

        next_s.drive.refresh_request_out = next_s.refresh_due;
        next_s.drive.refresh_status_pin = next_s.mode.column_extend_option
            ? (next_s.state == vrc_pkg::VRC_REF) : next_s.refresh_due;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_ext_holds_cas;
        (s.state == vrc_pkg::VRC_COL && !p.access_request && !grant_changed && !s.mode.interleave_mode
            && !s.mode.column_extend_option && p.column_extend_inputs != 2'h0) |=> s.drive.cas;
    endproperty
    a_ext_holds_cas: assert property (p_ext_holds_cas) else $error("cas not extended");

    property p_ras_drops;
        (s.state == vrc_pkg::VRC_COL && !p.access_request) |=> !s.drive.ras;
    endproperty
    a_ras_drops: assert property (p_ras_drops) else $error("ras held after request drop");

    property p_ack_drops;
        (s.state == vrc_pkg::VRC_COL && !p.access_request) |=> !s.drive.transfer_acknowledge;
    endproperty
    a_ack_drops: assert property (p_ack_drops) else $error("acknowledge held");

    property p_write_no_oe;
        (s.state == vrc_pkg::VRC_COL && p.access_is_write) |=> !s.drive.transfer_output_enable;
    endproperty
    a_write_no_oe: assert property (p_write_no_oe) else $error("output enable on write");

    property p_shift_follow;
        (s.state == vrc_pkg::VRC_IDLE && !s.mode.column_extend_option && !p.program_strobe
            && p.shift_load_request) |=> s.drive.transfer_output_enable;
    endproperty
    a_shift_follow: assert property (p_shift_follow) else $error("output enable not following");

    property p_shift_release;
        (s.state == vrc_pkg::VRC_IDLE && !p.shift_load_request) |=> !s.drive.transfer_output_enable;
    endproperty
    a_shift_release: assert property (p_shift_release) else $error("output enable stuck");

    property p_shift_fourth;
        (s.state == vrc_pkg::VRC_IDLE && s.mode.column_extend_option && !p.program_strobe
            && p.shift_load_request && s.shift_edges == 3'h3)
            |=> !s.drive.transfer_output_enable ##1 (!s.drive.transfer_output_enable || !p.shift_load_request);
    endproperty
    a_shift_fourth: assert property (p_shift_fourth) else $error("output enable past fourth edge");

    property p_grant_delay;
        grant_changed && !p.program_strobe
            |=> s.grant_wait == (s.mode.ras_timing_bit_low ? 2'h2 : 2'h1);
    endproperty
    a_grant_delay: assert property (p_grant_delay) else $error("grant delay wrong");

    property p_counter_clear;
        clear |=> s.refresh_cnt == 9'h000 ##1 s.refresh_cnt == 9'h001;
    endproperty
    a_counter_clear: assert property (p_counter_clear) else $error("refresh counter not cleared");

    property p_request_raised;
        tick |=> s.drive.refresh_request_out;
    endproperty
    a_request_raised: assert property (p_request_raised) else $error("refresh request missing");

    c_extended_cas: cover property (s.state == vrc_pkg::VRC_EXT ##1 s.state == vrc_pkg::VRC_PRE);
    c_long_shift: cover property (s.shift_edges == vrc_pkg::VRC_SHIFT_EDGES && p.shift_load_request);
    c_refresh: cover property (s.state == vrc_pkg::VRC_REF);
    c_clear: cover property (clear);

endmodule

`default_nettype wire

/* inc/vrc_pkg.sv */
package vrc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int VRC_CLK_PERIOD_NS = 40;
    localparam int VRC_REFRESH_PERIOD_NS = 15000;
    localparam int VRC_REFRESH_CYCLES = VRC_REFRESH_PERIOD_NS / VRC_CLK_PERIOD_NS;
    localparam int VRC_CLEAR_NS = 500;
    localparam int VRC_CLEAR_CYCLES = (VRC_CLEAR_NS + VRC_CLK_PERIOD_NS - 1) / VRC_CLK_PERIOD_NS;
    localparam logic [8:0] VRC_REFRESH_LAST = 9'(VRC_REFRESH_CYCLES - 1);
    localparam logic [3:0] VRC_CLEAR_LAST = 4'(VRC_CLEAR_CYCLES - 1);
    localparam logic [3:0] VRC_CLEAR_DONE = 4'(VRC_CLEAR_CYCLES);
    localparam logic [2:0] VRC_SHIFT_EDGES = 3'h4;
    localparam logic [1:0] VRC_GRANT_DELAY_SHORT = 2'h1;
    localparam logic [1:0] VRC_GRANT_DELAY_LONG = 2'h2;

    // ****************************************
    // ras precharge / refresh low times in clocks, per timing bit pair
    // ****************************************
    localparam logic [2:0] VRC_PRE_00 = 3'h1;
    localparam logic [2:0] VRC_PRE_01 = 3'h2;
    localparam logic [2:0] VRC_PRE_10 = 3'h2;
    localparam logic [2:0] VRC_PRE_11 = 3'h3;
    localparam logic [2:0] VRC_REF_00 = 3'h2;
    localparam logic [2:0] VRC_REF_01 = 3'h2;
    localparam logic [2:0] VRC_REF_10 = 3'h3;
    localparam logic [2:0] VRC_REF_11 = 3'h4;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {VRC_IDLE, VRC_PRE, VRC_ROW, VRC_COL, VRC_EXT, VRC_REF} vrc_state_type;

    typedef struct packed {
        logic access_request;
        logic access_is_write;
        logic [1:0] column_extend_inputs;
        logic shift_load_request;
        logic second_port_grant;
        logic internal_refresh_disable;
        logic refresh_strobe_in;
        logic column_increment_in;
        logic program_strobe;
        logic column_extend_option_input;
        logic ras_timing_bit_low;
        logic ras_timing_bit_high;
        logic interleave_mode;
    } vrc_pins_type;

    typedef struct packed {
        logic column_extend_option;
        logic ras_timing_bit_low;
        logic ras_timing_bit_high;
        logic interleave_mode;
    } vrc_mode_type;

    typedef struct packed {
        logic ras;
        logic cas;
        logic transfer_output_enable;
        logic transfer_acknowledge;
        logic refresh_request_out;
        logic refresh_status_pin;
    } vrc_drive_type;

endpackage
